// *** rtl/ref_ladder_dac_control.v ***
// Purpose: control logic for a 32-level resistor ladder reference with
//          two pin outputs, reached over classic Wishbone.
// Assumes: single clock ref_clk at 100 MHz; pads are asynchronous.
// Notes:   the analog ladder and switches sit outside this block.
`timescale 1ns/1ps
`include "ref_ladder_consts.vh"
module ref_ladder_dac_control (
    // Clock, reset and clock enable
    input  wire                ref_clk,
    input  wire                resetn,
    input  wire                ce,
    // Wishbone slave
    input  wire                cyc,
    input  wire                stb,
    input  wire                we,
    input  wire [`ADR_W-1:0]   adr,
    input  wire [3:0]          sel,
    input  wire [31:0]         wdata,
    output reg  [31:0]         rdata,
    output reg                 ack,
    // System wake indication
    input  wire                sleep_wake,
    // Ladder switch controls
    output reg                 converter_on,
    output reg                 ladder_low_power_select,
    output reg                 ladder_top_connect,
    output reg                 ladder_bottom_connect,
    output reg  [2:0]          positive_source_level,
    output reg                 negative_source_vref,
    output reg                 negative_source_gnd,
    output reg  [`LEVELS-1:0]  tap_select,
    output reg                 clamp_positive,
    output reg                 clamp_negative,
    // Reference output pin 1
    input  wire                pin1_gpio_out,
    input  wire                pin1_gpio_oe,
    output wire                pin1_gpio_in,
    input  wire                pin1_pad_in,
    output wire                pin1_pad_out,
    output wire                pin1_pad_oe,
    output wire                reference_output_pin1,
    // Reference output pin 2
    input  wire                pin2_gpio_out,
    input  wire                pin2_gpio_oe,
    output wire                pin2_gpio_in,
    input  wire                pin2_pad_in,
    output wire                pin2_pad_out,
    output wire                pin2_pad_oe,
    output wire                reference_output_pin2
);

////////////////////////////////////////////////////////////////////////////
// Helpers

function [`LEVELS-1:0] tap_decode;
    input [`CODE_W-1:0] code;
    begin
        tap_decode = {{(`LEVELS-1){1'b0}}, 1'b1} << code;
    end
endfunction

function [2:0] source_decode;
    input [1:0] pss;
    begin
        case (pss)
            `PSS_SUPPLY:    source_decode = 3'h1;
            `PSS_EXT_PIN:   source_decode = 3'h2;
            `PSS_FIXED_REF: source_decode = 3'h4;
            default:        source_decode = 3'h0;
        endcase
    end
endfunction

// Byte-lane merge of a masked register write.
function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] data;
    input [7:0] wmask;
    begin
        merge_byte = (old & ~wmask) | (data & wmask);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Stored fields

reg  [7:0] ref_control_main;
reg  [7:0] ref_level_select;
reg  [7:0] ref_aux_control;
reg  [7:0] next_control;
reg  [7:0] next_level;
reg  [7:0] next_aux;

wire       wr_take;
wire       rd_take;
wire       hit_ctrl;
wire       hit_level;
wire       hit_status;
wire       hit_aux;

// Requests are taken only in the first cycle, before ack, so a master
// that still holds its strobe in the ack cycle cannot act twice.
assign wr_take    = cyc & stb & we & ~ack & sel[0];
assign rd_take    = cyc & stb & ~we & ~ack;
assign hit_ctrl   = (adr == `ADDR_CTRL);
assign hit_level  = (adr == `ADDR_LEVEL);
assign hit_status = (adr == `ADDR_STATUS);
assign hit_aux    = (adr == `ADDR_AUX);

always @* begin
    next_control = ref_control_main;
    next_level   = ref_level_select;
    next_aux     = ref_aux_control;
    if (wr_take && hit_ctrl) begin
        next_control = merge_byte(ref_control_main, wdata[7:0],
                                  `CTRL_WMASK);
    end
    if (wr_take && hit_level) begin
        next_level = merge_byte(ref_level_select, wdata[7:0],
                                `LEVEL_WMASK);
    end
    if (wr_take && hit_aux) begin
        next_aux = merge_byte(ref_aux_control, wdata[7:0], `AUX_WMASK);
    end
end

// Only the reset clears the fields; waking from sleep is not a reset, so
// sleep_wake deliberately has no path into this process.
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        ref_control_main <= `CTRL_RESET;
    end else if (ce) begin
        ref_control_main <= next_control;
    end
end

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        ref_level_select <= `LEVEL_RESET;
    end else if (ce) begin
        ref_level_select <= next_level;
    end
end

// The low-power select sits in a register of its own because every spare
// bit of the control register must read as zero.
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        ref_aux_control  <= `AUX_RESET;
    end else if (ce) begin
        ref_aux_control  <= next_aux;
    end
end

////////////////////////////////////////////////////////////////////////////
// Ladder switch decode from the next field values, so that the switches
// move on the very edge that stores a write.

wire                next_en;
wire                next_lps;
wire [1:0]          next_pss;
wire                next_nss;
wire [`CODE_W-1:0]  next_code;
wire                next_oe1;
wire                next_oe2;

assign next_en   = next_control[`CTRL_EN_BIT];
assign next_lps  = next_aux[`AUX_LPS_BIT];
assign next_pss  = next_control[`CTRL_PSS_HI:`CTRL_PSS_LO];
assign next_nss  = next_control[`CTRL_NSS_BIT];
assign next_code = next_level[`CODE_W-1:0];
assign next_oe1  = next_control[`CTRL_OE1_BIT];
assign next_oe2  = next_control[`CTRL_OE2_BIT];

wire next_clamp_pos = ~next_en & next_lps &
                      (next_code == `CODE_ALL_ONES);
wire next_clamp_neg = ~next_en & ~next_lps &
                      (next_code == `CODE_ALL_ZEROS);

// While enabled both ends stay on for the full ratiometric range; when
// disabled, the low-power select decides which end is dropped.
wire next_top    = next_en | next_lps;
wire next_bottom = next_en | ~next_lps;

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        converter_on            <= 1'b0;
        ladder_low_power_select <= 1'b0;
        ladder_top_connect      <= 1'b0;
        ladder_bottom_connect   <= 1'b1;
    end else if (ce) begin
        converter_on            <= next_en;
        ladder_low_power_select <= next_lps;
        ladder_top_connect      <= next_top;
        ladder_bottom_connect   <= next_bottom;
    end
end

// Source selects follow the stored codes even while the converter is
// off, so a clamp state already sits on the wanted source.
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        positive_source_level   <= 3'h1;
        negative_source_vref    <= 1'b0;
        negative_source_gnd     <= 1'b1;
    end else if (ce) begin
        positive_source_level   <= source_decode(next_pss);
        negative_source_vref    <= next_nss;
        negative_source_gnd     <= ~next_nss;
    end
end

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        tap_select              <= {`LEVELS{1'b0}};
        clamp_positive          <= 1'b0;
        clamp_negative          <= 1'b1;
    end else if (ce) begin
        // A tap is closed only where the output is defined: enabled, or in
        // one of the two clamp states.
        if (next_en || next_clamp_pos || next_clamp_neg) begin
            tap_select <= tap_decode(next_code);
        end else begin
            tap_select <= {`LEVELS{1'b0}};
        end
        clamp_positive <= next_clamp_pos;
        clamp_negative <= next_clamp_neg;
    end
end

////////////////////////////////////////////////////////////////////////////
// Pins

wire [1:0] pad_level;

// Both pads are asynchronous, so two flops stand before any logic reads
// them; the first flop feeds nothing else.

level_sync #(
    .WIDTH    (`SYNC_STAGES)
) u_pad_sync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .ce       (ce),
    .async_in ({pin2_pad_in, pin1_pad_in}),
    .sync_out (pad_level)
);

pin_override u_pin1 (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .ce          (ce),
    .route       (next_oe1),
    .gpio_out    (pin1_gpio_out),
    .gpio_oe     (pin1_gpio_oe),
    .gpio_in     (pin1_gpio_in),    
    .pad_level   (pad_level[0]),
    .pad_out     (pin1_pad_out),
    .pad_oe      (pin1_pad_oe),
    .ref_connect (reference_output_pin1)
);

pin_override u_pin2 (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .ce          (ce),
    .route       (next_oe2),
    .gpio_out    (pin2_gpio_out),
    .gpio_oe     (pin2_gpio_oe),
    .gpio_in     (pin2_gpio_in),
    .pad_level   (pad_level[1]),
    .pad_out     (pin2_pad_out),
    .pad_oe      (pin2_pad_oe),
    .ref_connect (reference_output_pin2)
);

////////////////////////////////////////////////////////////////////////////
// Wake tracking: a sticky flag records wake events seen while ce is high, so software
// can see that a wake passed without disturbing the control fields.

reg        wake_seen;

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        wake_seen <= 1'b0;
    end else if (ce) begin
        if (sleep_wake) begin
            wake_seen <= 1'b1;
        end else if (wr_take && hit_status && wdata[7]) begin
            wake_seen <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Status word, built from the block's outputs and its wake and reserved-code flags.

wire       pss_reserved;

// A reserved source code is stored and read back, but closes no source
// switch; this flag lets software spot it.
assign pss_reserved =
    (ref_control_main[`CTRL_PSS_HI:`CTRL_PSS_LO] == `PSS_RESERVED);

// The pin bits read through the override, so a routed pin reads zero.
wire [7:0] status_word = {
    wake_seen,
    pss_reserved,
    pin2_gpio_in,
    pin1_gpio_in,
    ladder_bottom_connect,
    ladder_top_connect,
    clamp_negative,
    clamp_positive
};

////////////////////////////////////////////////////////////////////////////
// Bus answer: one wait state, ack for one cycle, unmapped reads give zero.

reg [7:0] read_byte;

always @* begin
    case (adr)
        `ADDR_CTRL:   read_byte = ref_control_main & `CTRL_WMASK;
        `ADDR_LEVEL:  read_byte = ref_level_select & `LEVEL_WMASK;
        `ADDR_STATUS: read_byte = status_word;
        `ADDR_AUX:    read_byte = ref_aux_control & `AUX_WMASK;
        default:      read_byte = 8'h00;
    endcase
end

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        ack <= 1'b0;
    end else if (ce) begin
        // Dropping ack after one cycle keeps a held strobe from being
        // answered twice; the master must lower it in between.
        ack <= cyc & stb & ~ack;
    end
end

// Read data is loaded once, on the taking edge, and then held, so it
// stands steady during the ack cycle and beyond.
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        rdata <= 32'h0000_0000;
    end else if (ce && rd_take) begin
        rdata <= {24'h00_0000, read_byte};
    end
end

endmodule // ref_ladder_dac_control

// *** rtl/ref_ladder_consts.vh ***
// Purpose: constants for the reference ladder converter control block.
// Assumes: 32-bit classic Wishbone, registers in the low byte of a word.
// Notes:   definitions only.
//
// Overview of operation
// - thirty-two levels chosen by five-bit code
// - level code in bits 4..0, read/write
// - enabled output is ratio of source span
// - disabled, low power, all ones: positive
// - disabled, normal, all zeros: negative source
// - low power drops one ladder end
// - output enable routes reference, kills digital
// - digital read of routed pin gives zero
// - pin enables at bits 5 and 4
// - positive source select in bits 3..2
// - negative source select at bit 0
// - enable bit at bit 7
// - unimplemented bits read as zero
// - sleep wake leaves control register alone
// - reset disables converter, disconnects pins
// - reset clears level code
`ifndef REF_LADDER_CONSTS_VH
`define REF_LADDER_CONSTS_VH

`define ADR_W            8
`define ADDR_CTRL        8'h00
`define ADDR_LEVEL       8'h04
`define ADDR_STATUS      8'h08
`define ADDR_AUX         8'h0c

`define CTRL_RESET       8'h00
`define LEVEL_RESET      8'h00
`define AUX_RESET        8'h00
`define CTRL_WMASK       8'hbd
`define LEVEL_WMASK      8'h1f
`define AUX_WMASK        8'h01

`define CTRL_EN_BIT      7
`define CTRL_OE1_BIT     5
`define CTRL_OE2_BIT     4
`define CTRL_PSS_HI      3
`define CTRL_PSS_LO      2
`define CTRL_NSS_BIT     0
`define AUX_LPS_BIT      0

`define CODE_W           5
`define LEVELS           32
`define CODE_ALL_ONES    5'h1f
`define CODE_ALL_ZEROS   5'h00

`define PSS_SUPPLY       2'h0
`define PSS_EXT_PIN      2'h1
`define PSS_FIXED_REF    2'h2
`define PSS_RESERVED     2'h3

`define SYNC_STAGES      2

`endif

// *** rtl/level_sync.v ***
// Purpose: two-stage synchroniser for asynchronous pad levels.
// Assumes: inputs are slow levels; no pulse is shorter than two cycles.
// Notes:   the first stage feeds only the second stage.
`timescale 1ns/1ps
module level_sync #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             resetn,
    input  wire             ce,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        meta     <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
        meta     <= async_in;
        sync_out <= meta;
    end
end

endmodule // level_sync

// *** rtl/pin_override.v ***
// Purpose: per-pin override of the digital path when the pin carries the
//          reference voltage.
// Assumes: pad_level is already synchronised; gpio signals share ref_clk.
// Notes:   route is the next value of the output enable field, so the pad
//          and the field change on the same edge.
`timescale 1ns/1ps
module pin_override (
    // Clock and reset
    input  wire ref_clk,
    input  wire resetn,
    input  wire ce,
    // Control
    input  wire route,
    // Port logic side
    input  wire gpio_out,
    input  wire gpio_oe,
    output reg  gpio_in,
    // Pad side
    input  wire pad_level,
    output reg  pad_out,
    output reg  pad_oe,
    output reg  ref_connect
);

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        pad_out     <= 1'b0;
        pad_oe      <= 1'b0;
        gpio_in     <= 1'b0;
        ref_connect <= 1'b0;
    end else if (ce) begin
        ref_connect <= route;
        // The driver is kept off so it cannot fight the weak reference.
        pad_oe      <= gpio_oe & ~route;
        pad_out     <= route ? 1'b0 : gpio_out;
        gpio_in     <= route ? 1'b0 : pad_level;
    end
end

endmodule // pin_override

// *** tb/ref_ladder_props.sv ***
// Purpose: concurrent checks on the ladder control block's ports.
// Assumes: one clock domain; ce is high except for one cycle where the bench drops it.
// Notes:   attached by bind after the module.
`timescale 1ns/1ps
`include "ref_ladder_consts.vh"
module ref_ladder_props (
    // Clock, reset and bus
    input wire                ref_clk,
    input wire                resetn,
    input wire                ce,
    input wire                cyc,
    input wire                stb,
    input wire                ack,
    input wire                sleep_wake,
    // Ladder switches
    input wire                converter_on,
    input wire                ladder_low_power_select,
    input wire                ladder_top_connect,
    input wire                ladder_bottom_connect,
    input wire [2:0]          positive_source_level,
    input wire                negative_source_vref,
    input wire                negative_source_gnd,
    input wire [`LEVELS-1:0]  tap_select,
    input wire                clamp_positive,
    input wire                clamp_negative,
    // Pins
    input wire                reference_output_pin1,
    input wire                pin1_gpio_in,
    input wire                pin1_pad_oe,
    input wire                reference_output_pin2,
    input wire                pin2_gpio_in,
    input wire                pin2_pad_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_ack; cyc && stb && !ack && ce |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack_pulse; ack && ce |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
    property p_clamp_pos;
        clamp_positive |-> !converter_on && ladder_low_power_select;
    endproperty
    a_clamp_pos: assert property (p_clamp_pos) else $error("clamp+");
    property p_clamp_neg;
        clamp_negative |-> !converter_on && !ladder_low_power_select;
    endproperty
    a_clamp_neg: assert property (p_clamp_neg) else $error("clamp-");
    property p_ends;
        ladder_top_connect == (converter_on | ladder_low_power_select) &&
        ladder_bottom_connect == (converter_on | !ladder_low_power_select);
    endproperty
    a_ends: assert property (p_ends) else $error("ladder ends");
    property p_taps; converter_on |-> $onehot(tap_select); endproperty
    a_taps: assert property (p_taps) else $error("taps");
    property p_route1;
        reference_output_pin1 |-> !pin1_gpio_in && !pin1_pad_oe;
    endproperty
    a_route1: assert property (p_route1) else $error("pin1 route");
    property p_route2;
        reference_output_pin2 |-> !pin2_gpio_in && !pin2_pad_oe;
    endproperty
    a_route2: assert property (p_route2) else $error("pin2 route");
    property p_nss; negative_source_vref != negative_source_gnd; endproperty
    a_nss: assert property (p_nss) else $error("neg source");
    property p_pss; $onehot0(positive_source_level); endproperty
    a_pss: assert property (p_pss) else $error("pos source");
    property p_wake;
        sleep_wake && !(cyc && stb) |=>
            $stable(converter_on) && $stable(reference_output_pin1);
    endproperty
    a_wake: assert property (p_wake) else $error("wake change");
endmodule // ref_ladder_props
bind ref_ladder_dac_control ref_ladder_props u_props (.*);

// *** tb/pad_model.sv ***
// Purpose: far side of one reference pin: the pad and its load.
// Assumes: same clock as the block.
// Notes:   a pad carrying the reference shows a changing level.
`timescale 1ns/1ps
module pad_model (
    input  wire  ref_clk,
    input  wire  pad_out,
    input  wire  pad_oe,
    input  wire  routed,
    output logic pad_in
);
    initial pad_in = 1'b0;
    // An analog level reads as noise, so toggle to catch a leaky override.
    always @(posedge ref_clk) begin
        pad_in <= routed ? ~pad_in : (pad_oe ? pad_out : ~pad_in);
    end
endmodule // pad_model

// *** tb/ref_ladder_dac_control_tb_top.sv ***
// Purpose: self-checking bench for the ladder control block.
// Assumes: classic Wishbone, ack after one cycle.
// Notes:   reads queue their expected data; a watcher compares.
`timescale 1ns/1ps
`include "ref_ladder_consts.vh"
module ref_ladder_dac_control_tb_top;
    logic ref_clk = 0, resetn = 0, ce = 1, cyc = 0, stb = 0, we = 0;
    logic sleep_wake = 0, g1o = 0, g1e = 0, g2o = 0, g2e = 0;
    logic [7:0] adr = 0, s, c;
    logic [3:0] sel = 0;
    logic [31:0] wdata = 0;
    logic [7:0] exp_q[$];
    int errors = 0, cmp_count = 0;
    wire ack, con, lps, top, bot, nv, ng, cp, cn, r1, r2;
    wire gi1, gi2, po1, po2, oe1, oe2, pi1, pi2;
    wire [2:0] psl;
    wire [31:0] rdata, taps;
    ref_ladder_dac_control uut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdata(wdata),
        .rdata(rdata), .ack(ack), .sleep_wake(sleep_wake),
        .converter_on(con), .ladder_low_power_select(lps),
        .ladder_top_connect(top), .ladder_bottom_connect(bot),
        .positive_source_level(psl), .negative_source_vref(nv),
        .negative_source_gnd(ng), .tap_select(taps),
        .clamp_positive(cp), .clamp_negative(cn),
        .pin1_gpio_out(g1o), .pin1_gpio_oe(g1e), .pin1_gpio_in(gi1),
        .pin1_pad_in(pi1), .pin1_pad_out(po1), .pin1_pad_oe(oe1),
        .reference_output_pin1(r1),
        .pin2_gpio_out(g2o), .pin2_gpio_oe(g2e), .pin2_gpio_in(gi2),
        .pin2_pad_in(pi2), .pin2_pad_out(po2), .pin2_pad_oe(oe2),
        .reference_output_pin2(r2));
    pad_model pad1 (.ref_clk(ref_clk), .pad_out(po1), .pad_oe(oe1),
        .routed(r1), .pad_in(pi1));
    pad_model pad2 (.ref_clk(ref_clk), .pad_out(po2), .pad_oe(oe2),
        .routed(r2), .pad_in(pi2));
    ////////////////////////////////////////////////////////////////////////
    function automatic [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task finish_test;
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic cycle; a read leaves its expected byte in the queue.
    task wb(input logic w, input [7:0] a, input [7:0] d, input [7:0] e);
        int n;
        @(posedge ref_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'h1;
        wdata <= {24'h0, d};
        if (!w) exp_q.push_back(e);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 0; stb <= 0; we <= 0;
        if (n >= 20) begin
            errors++;
            finish_test;
        end
    endtask
    always @(posedge ref_clk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            check(rdata, {24'h0, exp_q.pop_front()});
    end
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1;
        wb(0, `ADDR_CTRL, 0, 8'h00);
        wb(0, `ADDR_LEVEL, 0, 8'h00);
        check({con, cn, r1, r2}, 4'b0100);
        s = 8'h5b;
        repeat (8) begin
            s = lfsr(s);
            wb(1, `ADDR_LEVEL, s, 0);
            wb(0, `ADDR_LEVEL, 0, s & 8'h1f);
        end
        g1e <= 1; g1o <= 1; g2e <= 1; g2o <= 1;
        wb(1, `ADDR_CTRL, 8'hff, 0);
        wb(0, `ADDR_CTRL, 0, 8'hbd);
        repeat (5) @(posedge ref_clk);
        check({r1, r2, oe1, oe2}, 4'b1100);
        check({gi1, gi2}, 2'b00);
        check({po1, po2}, 2'b00);
        wb(1, `ADDR_CTRL, 8'h80, 0);
        repeat (5) @(posedge ref_clk);
        check({oe1, po1, gi1, gi2}, 4'b1111);
        for (c = 0; c < 32; c++) begin
            wb(1, `ADDR_LEVEL, c, 0);
            check(taps, 32'h1 << c);
            check({con, top, bot}, 3'b111);
        end
        for (c = 0; c < 4; c++) begin
            wb(1, `ADDR_CTRL, (c << 2) | {7'h0, c[0]}, 0);
            check(psl, (c == 3) ? 3'b000 : 3'b001 << c);
            check({nv, ng, con}, {c[0], ~c[0], 1'b0});
        end
        wb(1, `ADDR_AUX, 8'h01, 0);
        wb(1, `ADDR_LEVEL, 8'h1f, 0);
        check({cp, cn, top, bot, lps}, 5'b10101);
        wb(1, `ADDR_AUX, 8'h00, 0);
        wb(1, `ADDR_LEVEL, 8'h00, 0);
        check({cp, cn, top, bot, lps}, 5'b01010);
        wb(1, `ADDR_CTRL, 8'ha5, 0);
        sleep_wake <= 1;
        @(posedge ref_clk);
        sleep_wake <= 0;
        wb(0, `ADDR_CTRL, 0, 8'ha5);
        wb(1, 8'h10, 8'hff, 0);
        wb(0, 8'h10, 0, 8'h00);
        wb(0, `ADDR_CTRL, 0, 8'ha5);
        wb(1, `ADDR_CTRL, 8'h05, 0);
        wb(1, `ADDR_STATUS, 8'h80, 0);
        wb(0, `ADDR_STATUS, 0, 8'h3a);
        ce <= 0;
        sleep_wake <= 1;
        @(posedge ref_clk);
        ce <= 1;
        sleep_wake <= 0;
        wb(0, `ADDR_STATUS, 0, 8'h3a);
        sleep_wake <= 1;
        @(posedge ref_clk);
        sleep_wake <= 0;
        wb(0, `ADDR_CTRL, 0, 8'h05);
        wb(0, `ADDR_STATUS, 0, 8'hba);
        wb(1, `ADDR_LEVEL, 8'h1f, 0);
        @(posedge ref_clk);
        resetn <= 0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1;
        wb(0, `ADDR_CTRL, 0, 8'h00);
        wb(0, `ADDR_LEVEL, 0, 8'h00);
        check({con, r1, r2}, 3'b000);
        repeat (2) @(posedge ref_clk);
        finish_test;
    end
endmodule // ref_ladder_dac_control_tb_top
